// file: cei_ctrl_model.sv
// model: controller that acknowledges interrupts after a chosen delay
`timescale 1ns/100ps
module cei_ctrl_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       irq_valid,
    input  wire logic [3:0] irq_code,
    input  wire logic [3:0] dly,
    output logic            irq_ack
);
    logic [3:0] cnt_r;
    logic [3:0] got_q[$];
    // long dly: slower than the event rate
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_ack <= 1'b0;
            cnt_r   <= 4'h0;
        end else if (irq_valid && irq_ack) begin
            irq_ack <= 1'b0;
            cnt_r   <= 4'h0;
            got_q.push_back(irq_code);
        end else if (irq_valid && cnt_r >= dly) begin
            irq_ack <= 1'b1;
        end else if (irq_valid) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

// file: cei_edge.sv
// module: synchroniser with rising and falling edge pulses for one level
`timescale 1ns/100ps
module cei_edge (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;

    always_comb begin
        sync_nxt = {sync_r[1:0], din};
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sync_r <= 3'h0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    // stage 0 is read only by stage 1
    assign level = sync_r[1];
    assign rise  = sync_r[1] & ~sync_r[2];
    assign fall  = ~sync_r[1] & sync_r[2];
endmodule

// file: cei_pkg.sv
// package: constants, types and register map of the event source
package cei_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_ENABLE    = 12'h000;
    localparam logic [11:0] ADDR_MODE      = 12'h004;
    localparam logic [11:0] ADDR_STATUS    = 12'h008;
    localparam logic [11:0] ADDR_EVENT     = 12'h00c;
    localparam logic [11:0] ADDR_LIMIT_HI  = 12'h010;
    localparam logic [11:0] ADDR_LIMIT_LO  = 12'h014;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          MODE_MEASURE_BIT = 0;
    localparam int          MODE_ABS_BIT     = 1;
    localparam int          MODE_MOTION_BIT  = 2;
    localparam int          DIRECTION_STATUS_BIT = 0;
    localparam int          STS_LOST_BIT     = 1;
    localparam int          STS_PEND_BIT     = 2;
    localparam int          STS_GATE_BIT     = 3;
    localparam int          EVT_VALID_BIT    = 8;
    localparam logic [9:0]  ENABLE_RST       = 10'h000;
    localparam logic [2:0]  MODE_RST         = 3'h0;
    localparam logic [31:0] LIMIT_HI_RST     = 32'h7fffffff;
    localparam logic [31:0] LIMIT_LO_RST     = 32'h80000000;
    localparam int          NUM_EVT          = 10;

    // ----------------------------------------------------------------
    // event indices (priority: lower index wins) and type codes
    // ----------------------------------------------------------------
    localparam int EV_CAPTURE = 0;
    localparam int EV_SYNC    = 1;
    localparam int EV_GSTART  = 2;
    localparam int EV_GSTOP   = 3;
    localparam int EV_OVFL    = 4;
    localparam int EV_UNFL    = 5;
    localparam int EV_DIR     = 6;
    localparam int EV_ZERO    = 7;
    localparam int EV_CMP0    = 8;
    localparam int EV_CMP1    = 9;

    localparam logic [3:0] CODE_CAPTURE = 4'h8;
    localparam logic [3:0] CODE_SYNC    = 4'h9;
    localparam logic [3:0] CODE_GSTART  = 4'h1;
    localparam logic [3:0] CODE_GSTOP   = 4'h2;
    localparam logic [3:0] CODE_OVFL    = 4'h3;
    localparam logic [3:0] CODE_UNFL    = 4'h4;
    localparam logic [3:0] CODE_DIR     = 4'ha;
    localparam logic [3:0] CODE_ZERO    = 4'h7;
    localparam logic [3:0] CODE_CMP0    = 4'h5;
    localparam logic [3:0] CODE_CMP1    = 4'h6;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        capture;
        logic        sync;
        logic        gate;
        logic        count_pulse;
        logic        value_change;
        logic [31:0] value;
        logic        compare_output_0;
        logic        compare_output_1;
    } cei_chan_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } cei_irq_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } cei_state_t;

endpackage

// file: cei_top.sv
// module: counter event detection, hardware interrupt request and apb register file
//
// Summary of operation
// - capture stored and enabled: code 1000
// - counter synchronised by zero mark or input edge: code 1001
// - internal gate opens and enabled: code 0001
// - internal gate closes and enabled: code 0010
// - counter above high limit and enabled: code 0011
// - counter below low limit and enabled: code 0100
// - value reverses direction and enabled: code 1010
// - direction bit resets to up; first value movement in either direction raises no direction event
// - value crosses zero and enabled: code 0111
// - first comparison output condition met: code 0101
// - second comparison output condition met: code 0110
// - incremental encoder: compare events only on count pulse changes
// - absolute encoder limits events; measuring drops capture; motion mode none
// - all event enables cleared at reset
// - own enables; fires when matching status condition fulfilled
// - events before acknowledge dropped, lost diagnostic set
`timescale 1ns/100ps
module cei_top (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire cei_pkg::cei_chan_t chan,
    input  wire logic              aux_digital_input,
    input  wire logic              irq_ack,
    output logic                   irq_valid,
    output logic      [3:0]        irq_code,
    output logic                   irq_lost
);
    // ----------------------------------------------------------------
    // pin input synchronisation
    // ----------------------------------------------------------------
    logic aux_level;
    logic aux_rise;

    cei_edge u_aux (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .din     (aux_digital_input),
        .level   (aux_level),
        .rise    (aux_rise),
        .fall    ()
    );

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [9:0]          enable_r,   enable_nxt;
    logic [2:0]          mode_r,     mode_nxt;
    logic [31:0]         lim_hi_r,   lim_hi_nxt;
    logic [31:0]         lim_lo_r,   lim_lo_nxt;
    logic [31:0]         prdata_r,   prdata_nxt;
    logic                pready_r,   pready_nxt;
    logic                pslverr_r,  pslverr_nxt;
    logic                dir_r,      dir_nxt;
    logic                gate_r,     gate_nxt;
    logic                cmp0_r,     cmp0_nxt;
    logic                cmp1_r,     cmp1_nxt;
    logic [31:0]         value_r,    value_nxt;
    logic [1:0]          seen_r,     seen_nxt;
    logic [9:0]          pend_r,     pend_nxt;
    logic                lost_r,     lost_nxt;
    cei_pkg::cei_irq_t   irq_r,      irq_nxt;
    cei_pkg::cei_state_t state_r,    state_nxt;

    // ----------------------------------------------------------------
    // apb slave: one wait state; a write lands at the pready edge
    // ----------------------------------------------------------------
    logic acc;
    logic wr_acc;
    logic lost_clr;
    logic mapped;

    assign acc    = psel & penable & ~pready_r;
    assign wr_acc = psel & penable & pready_r & pwrite;

    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            cei_pkg::ADDR_ENABLE,
            cei_pkg::ADDR_MODE,
            cei_pkg::ADDR_STATUS,
            cei_pkg::ADDR_EVENT,
            cei_pkg::ADDR_LIMIT_HI,
            cei_pkg::ADDR_LIMIT_LO: mapped = 1'b1;
            default:                mapped = 1'b0;
        endcase
    end

    always_comb begin
        enable_nxt  = enable_r;
        mode_nxt    = mode_r;
        lim_hi_nxt  = lim_hi_r;
        lim_lo_nxt  = lim_lo_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = acc;
        pslverr_nxt = acc & ~mapped;
        lost_clr    = 1'b0;
        if (wr_acc) begin
            unique case (paddr)
                cei_pkg::ADDR_ENABLE:   enable_nxt = pwdata[9:0];
                cei_pkg::ADDR_MODE:     mode_nxt   = pwdata[2:0];
                cei_pkg::ADDR_STATUS:   lost_clr   = pwdata[cei_pkg::STS_LOST_BIT];
                cei_pkg::ADDR_LIMIT_HI: lim_hi_nxt = pwdata;
                cei_pkg::ADDR_LIMIT_LO: lim_lo_nxt = pwdata;
                default:                lost_clr   = 1'b0;
            endcase
        end
        if (acc & ~pwrite) begin
            prdata_nxt = 32'h0;
            unique case (paddr)
                cei_pkg::ADDR_ENABLE:   prdata_nxt[9:0] = enable_r;
                cei_pkg::ADDR_MODE:     prdata_nxt[2:0] = mode_r;
                cei_pkg::ADDR_STATUS: begin
                    prdata_nxt[cei_pkg::DIRECTION_STATUS_BIT] = dir_r;
                    prdata_nxt[cei_pkg::STS_LOST_BIT] = lost_r;
                    prdata_nxt[cei_pkg::STS_PEND_BIT] = |pend_r;
                    prdata_nxt[cei_pkg::STS_GATE_BIT] = gate_r;
                end
                cei_pkg::ADDR_EVENT: begin
                    prdata_nxt[3:0]                    = irq_r.code;
                    prdata_nxt[cei_pkg::EVT_VALID_BIT] = irq_r.valid;
                end
                cei_pkg::ADDR_LIMIT_HI: prdata_nxt = lim_hi_r;
                cei_pkg::ADDR_LIMIT_LO: prdata_nxt = lim_lo_r;
                default:                prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            enable_r  <= cei_pkg::ENABLE_RST;
            mode_r    <= cei_pkg::MODE_RST;
            lim_hi_r  <= cei_pkg::LIMIT_HI_RST;
            lim_lo_r  <= cei_pkg::LIMIT_LO_RST;
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            enable_r  <= enable_nxt;
            mode_r    <= mode_nxt;
            lim_hi_r  <= lim_hi_nxt;
            lim_lo_r  <= lim_lo_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    logic        measuring;
    logic        absolute;
    logic        motion;
    logic [9:0]  avail;
    logic [9:0]  raw;
    logic [9:0]  fire;
    logic        sgn_old;
    logic        sgn_new;
    logic        moved;
    logic        going_down;

    assign measuring  = mode_r[cei_pkg::MODE_MEASURE_BIT];
    assign absolute   = mode_r[cei_pkg::MODE_ABS_BIT];
    assign motion     = mode_r[cei_pkg::MODE_MOTION_BIT];
    assign moved      = chan.value_change & seen_r[0] & (chan.value != value_r);
    assign going_down = $signed(chan.value) < $signed(value_r);
    assign sgn_old    = value_r[31];
    assign sgn_new    = chan.value[31];

    always_comb begin
        avail = 10'h3ff;
        if (absolute) begin
            avail = 10'h0;
            avail[cei_pkg::EV_CAPTURE] = 1'b1;
            avail[cei_pkg::EV_DIR]     = 1'b1;
            avail[cei_pkg::EV_ZERO]    = 1'b1;
            avail[cei_pkg::EV_CMP0]    = 1'b1;
            avail[cei_pkg::EV_CMP1]    = 1'b1;
        end
        if (measuring) begin
            avail[cei_pkg::EV_CAPTURE] = 1'b0;
        end
        if (motion) begin
            avail = 10'h0;
        end
    end

    always_comb begin
        raw = 10'h0;
        raw[cei_pkg::EV_CAPTURE] = chan.capture;
        raw[cei_pkg::EV_SYNC]    = chan.sync;
        raw[cei_pkg::EV_GSTART]  = chan.gate & ~gate_r;
        raw[cei_pkg::EV_GSTOP]   = ~chan.gate & gate_r;
        raw[cei_pkg::EV_OVFL]    = moved & ($signed(chan.value) > $signed(lim_hi_r));
        raw[cei_pkg::EV_UNFL]    = moved & ($signed(chan.value) < $signed(lim_lo_r));
        raw[cei_pkg::EV_DIR]     = moved & seen_r[1] & (going_down != dir_r);
        raw[cei_pkg::EV_ZERO]    = moved & ((sgn_old != sgn_new) | (chan.value == 32'h0)
                                            & (value_r != 32'h0));
        raw[cei_pkg::EV_CMP0]    = chan.compare_output_0 & ~cmp0_r;
        raw[cei_pkg::EV_CMP1]    = chan.compare_output_1 & ~cmp1_r;
        if (!absolute && !chan.count_pulse) begin
            raw[cei_pkg::EV_CMP0] = 1'b0;
            raw[cei_pkg::EV_CMP1] = 1'b0;
        end
        fire = raw & avail & enable_r;
    end

    // ----------------------------------------------------------------
    // tracked status
    // ----------------------------------------------------------------
    always_comb begin
        gate_nxt  = chan.gate;
        cmp0_nxt  = chan.compare_output_0;
        cmp1_nxt  = chan.compare_output_1;
        dir_nxt   = dir_r;
        value_nxt = value_r;
        seen_nxt  = seen_r;
        if (chan.value_change) begin
            value_nxt   = chan.value;
            seen_nxt[0] = 1'b1;
        end
        if (moved) begin
            dir_nxt     = going_down;
            seen_nxt[1] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            gate_r  <= 1'b0;
            cmp0_r  <= 1'b0;
            cmp1_r  <= 1'b0;
            dir_r   <= 1'b0;
            value_r <= 32'h0;
            seen_r  <= 2'h0;
        end else begin
            gate_r  <= gate_nxt;
            cmp0_r  <= cmp0_nxt;
            cmp1_r  <= cmp1_nxt;
            dir_r   <= dir_nxt;
            value_r <= value_nxt;
            seen_r  <= seen_nxt;
        end
    end

    // ----------------------------------------------------------------
    // request presentation and acknowledge
    // ----------------------------------------------------------------
    function automatic logic [3:0] code_of(input int idx);
        logic [3:0] c;
        c = cei_pkg::CODE_CMP1;
        unique case (idx)
            cei_pkg::EV_CAPTURE: c = cei_pkg::CODE_CAPTURE;
            cei_pkg::EV_SYNC:    c = cei_pkg::CODE_SYNC;
            cei_pkg::EV_GSTART:  c = cei_pkg::CODE_GSTART;
            cei_pkg::EV_GSTOP:   c = cei_pkg::CODE_GSTOP;
            cei_pkg::EV_OVFL:    c = cei_pkg::CODE_OVFL;
            cei_pkg::EV_UNFL:    c = cei_pkg::CODE_UNFL;
            cei_pkg::EV_DIR:     c = cei_pkg::CODE_DIR;
            cei_pkg::EV_ZERO:    c = cei_pkg::CODE_ZERO;
            cei_pkg::EV_CMP0:    c = cei_pkg::CODE_CMP0;
            default:             c = cei_pkg::CODE_CMP1;
        endcase
        return c;
    endfunction

    logic [9:0] work;
    logic [9:0] pick;
    logic       hit;

    always_comb begin
        state_nxt = state_r;
        irq_nxt   = irq_r;
        pend_nxt  = pend_r;
        lost_nxt  = lost_r & ~lost_clr;
        work      = pend_r;
        pick      = 10'h0;
        hit       = 1'b0;
        unique case (state_r)
            cei_pkg::ST_IDLE: begin
                work = pend_r | fire;
                for (int i = 0; i < cei_pkg::NUM_EVT; i++) begin
                    if (work[i] && !hit) begin
                        hit     = 1'b1;
                        pick[i] = 1'b1;
                        irq_nxt.code = code_of(i);
                    end
                end
                pend_nxt = work & ~pick;
                if (hit) begin
                    irq_nxt.valid = 1'b1;
                    state_nxt     = cei_pkg::ST_WAIT;
                end
            end
            cei_pkg::ST_WAIT: begin
                // repeated or unacknowledged event is dropped
                if ((fire & pend_r) != 10'h0 || (fire & ~pend_r) != 10'h0
                    && (pend_r != 10'h0 || !irq_ack)) begin
                    lost_nxt = 1'b1;
                end
                if ((fire & pend_r) == 10'h0 && pend_r == 10'h0) begin
                    pend_nxt = fire & {10{irq_ack}};
                end
                if (irq_ack) begin
                    irq_nxt.valid = 1'b0;
                    state_nxt     = cei_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = cei_pkg::ST_IDLE;
                irq_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r <= cei_pkg::ST_IDLE;
            irq_r   <= '0;
            pend_r  <= 10'h0;
            lost_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            irq_r   <= irq_nxt;
            pend_r  <= pend_nxt;
            lost_r  <= lost_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign irq_valid = irq_r.valid;
    assign irq_code  = irq_r.code;
    assign irq_lost  = lost_r;

    // auxiliary input level and rise are synchronised but feed no event and no output
    logic aux_unused;
    assign aux_unused = aux_level & aux_rise;
endmodule

// file: cei_top_properties.sv
// checker: concurrent properties of the event source
`timescale 1ns/100ps
module cei_top_properties (
    input wire logic               clk_sys,
    input wire logic               rst_b,
    input wire logic [11:0]        paddr,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire cei_pkg::cei_chan_t chan,
    input wire logic               aux_digital_input,
    input wire logic               irq_ack,
    input wire logic               irq_valid,
    input wire logic [3:0]         irq_code,
    input wire logic               irq_lost
);
    logic [9:0] en_r;
    logic [9:0] en_nxt;
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    logic       wr_done;
    logic       mapped;
    // ----------------------------------------------------------------
    // shadow of enables and mode, taken when a write is answered
    // ----------------------------------------------------------------
    always_comb begin
        wr_done  = psel && penable && pready && pwrite;
        mapped   = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h5;
        en_nxt   = (wr_done && paddr == cei_pkg::ADDR_ENABLE) ? pwdata[9:0] : en_r;
        mode_nxt = (wr_done && paddr == cei_pkg::ADDR_MODE) ? pwdata[2:0] : mode_r;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            en_r   <= cei_pkg::ENABLE_RST;
            mode_r <= cei_pkg::MODE_RST;
        end else begin
            en_r   <= en_nxt;
            mode_r <= mode_nxt;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("stray pready");
    a_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong");
    a_unmapped_zero: assert property (pready && !mapped && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_clear: assert property ($rose(rst_b) |-> !irq_valid && !irq_lost && !pready)
        else $error("outputs not clear");
    a_hold_code: assert property (irq_valid && !irq_ack |=> irq_valid && $stable(irq_code))
        else $error("request dropped early");
    a_ack_fall: assert property (irq_valid && irq_ack |=> !irq_valid)
        else $error("request held after ack");
    a_capture_code: assert property (!psel && !irq_valid && $past(!irq_valid) && chan.capture
        && en_r[0] && mode_r == 3'h0 |=> irq_valid && irq_code == cei_pkg::CODE_CAPTURE)
        else $error("no capture request");
    a_motion_quiet: assert property ($rose(irq_valid) |-> !($past(mode_r[2]) && $past(mode_r[2], 2)))
        else $error("request in motion mode");
    a_lost_sticky: assert property (irq_lost && !psel |=> irq_lost)
        else $error("lost flag cleared");
    a_lost_cause: assert property ($rose(irq_lost) |-> $past(irq_valid) || $past(irq_valid, 2))
        else $error("lost flag set while idle");
endmodule
bind cei_top cei_top_properties u_props (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan(chan), .aux_digital_input(aux_digital_input),
    .irq_ack(irq_ack), .irq_valid(irq_valid), .irq_code(irq_code), .irq_lost(irq_lost));

// file: cei_top_test.sv
// testbench: interrupt scenarios of the event source
`timescale 1ns/100ps
module cei_top_test;
    logic               clk_sys;
    logic               rst_b;
    logic [11:0]        paddr;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    cei_pkg::cei_chan_t chan;
    logic               irq_ack;
    logic               irq_valid;
    logic [3:0]         irq_code;
    logic               irq_lost;
    logic [3:0]         dly;
    logic [31:0]        rdat;
    logic               rerr;
    int                 fails;
    int                 total_checks;

    cei_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan(chan), .aux_digital_input(1'b0),
        .irq_ack(irq_ack), .irq_valid(irq_valid), .irq_code(irq_code), .irq_lost(irq_lost));
    cei_ctrl_model u_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .irq_valid(irq_valid),
        .irq_code(irq_code), .dly(dly), .irq_ack(irq_ack));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rdat);
        chk("pslverr", 32'(ee), 32'(rerr));
    endtask
    // f bits 6..0: capture sync gate cmp0 cmp1 count_pulse value_change
    task automatic ev(input logic [6:0] f, input logic [31:0] v);
        @(posedge clk_sys);
        chan.capture          <= f[6];
        chan.sync             <= f[5];
        chan.gate             <= f[4];
        chan.compare_output_0 <= f[3];
        chan.compare_output_1 <= f[2];
        chan.count_pulse      <= f[1];
        chan.value_change     <= f[0];
        if (f[0]) chan.value <= v;
        @(posedge clk_sys);
        chan.capture      <= 1'b0;
        chan.sync         <= 1'b0;
        chan.value_change <= 1'b0;
    endtask
    // first presented code in the low nibble
    task automatic expect_codes(input int n, input logic [15:0] codes);
        repeat (24) @(posedge clk_sys);
        chk("irq count", 32'(n), 32'(u_ctrl.got_q.size()));
        for (int i = 0; i < n && i < u_ctrl.got_q.size(); i++)
            chk("irq_code", 32'(codes[i*4+:4]), 32'(u_ctrl.got_q[i]));
        u_ctrl.got_q.delete();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        rd_chk(cei_pkg::ADDR_ENABLE, 32'h0, 1'b0);
        rd_chk(cei_pkg::ADDR_MODE, 32'h0, 1'b0);
        rd_chk(cei_pkg::ADDR_STATUS, 32'h0, 1'b0);
        rd_chk(cei_pkg::ADDR_LIMIT_HI, 32'h7fffffff, 1'b0);
        rd_chk(cei_pkg::ADDR_LIMIT_LO, 32'h80000000, 1'b0);
        apb(1'b1, 12'h018, 32'hffffffff);
        rd_chk(12'h018, 32'h0, 1'b1);
        ev(7'h62, 32'h0);
        expect_codes(0, 16'h0);
    endtask
    task automatic t_value_events();
        apb(1'b1, cei_pkg::ADDR_ENABLE, 32'h3ff);
        rd_chk(cei_pkg::ADDR_ENABLE, 32'h3ff, 1'b0);
        apb(1'b1, cei_pkg::ADDR_LIMIT_HI, 32'h0000000a);
        apb(1'b1, cei_pkg::ADDR_LIMIT_LO, 32'hfffffff6);
        ev(7'h03, 32'h5);
        ev(7'h03, 32'h3);
        expect_codes(0, 16'h0);
        ev(7'h03, 32'h7);
        expect_codes(1, 16'h000a);
        ev(7'h03, 32'hfffffffe);
        expect_codes(2, 16'h007a);
        ev(7'h03, 32'h0000000c);
        expect_codes(3, 16'h07a3);
        ev(7'h03, 32'hfffffff4);
        expect_codes(3, 16'h07a4);
    endtask
    task automatic t_pulse_events();
        ev(7'h72, 32'h0);
        expect_codes(3, 16'h0198);
        ev(7'h02, 32'h0);
        expect_codes(1, 16'h0002);
        ev(7'h0a, 32'h0);
        ev(7'h0e, 32'h0);
        ev(7'h02, 32'h0);
        expect_codes(2, 16'h0065);
        ev(7'h0c, 32'h0);
        ev(7'h02, 32'h0);
        expect_codes(0, 16'h0);
    endtask
    task automatic t_modes();
        apb(1'b1, cei_pkg::ADDR_MODE, 32'h2);
        ev(7'h12, 32'h0);
        ev(7'h42, 32'h0);
        expect_codes(1, 16'h0008);
        apb(1'b1, cei_pkg::ADDR_MODE, 32'h1);
        ev(7'h62, 32'h0);
        expect_codes(1, 16'h0009);
        apb(1'b1, cei_pkg::ADDR_MODE, 32'h4);
        ev(7'h72, 32'h0);
        ev(7'h02, 32'h0);
        expect_codes(0, 16'h0);
        apb(1'b1, cei_pkg::ADDR_MODE, 32'h0);
        apb(1'b1, cei_pkg::ADDR_ENABLE, 32'h3fe);
        ev(7'h42, 32'h0);
        expect_codes(0, 16'h0);
        apb(1'b1, cei_pkg::ADDR_ENABLE, 32'h3ff);
    endtask
    task automatic t_lost();
        dly <= 4'h8;
        ev(7'h42, 32'h0);
        ev(7'h42, 32'h0);
        expect_codes(1, 16'h0008);
        chk("irq_lost", 32'h1, 32'(irq_lost));
        apb(1'b0, cei_pkg::ADDR_STATUS, 32'h0);
        chk("lost status", 32'h1, 32'(rdat[cei_pkg::STS_LOST_BIT]));
        apb(1'b1, cei_pkg::ADDR_STATUS, 32'h2);
        @(posedge clk_sys);
        chk("irq_lost", 32'h0, 32'(irq_lost));
        dly <= 4'h0;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #(20000 * 100);
        fails++;
        test_done();
    end
    initial begin
        fails        = 0;
        total_checks = 0;
        rst_b   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        chan    = '0;
        dly     = 4'h0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset_values();
        t_value_events();
        t_pulse_events();
        t_modes();
        t_lost();
        test_done();
    end
endmodule
